// ### verilog/hsmb_bridge.sv
// Host to shared buffer bridge: I/O control registers, memory
// window decode, host cycle sequencing and buffer port mux.
// Assumes a synchronous RAM with read data one cycle after enable.
`timescale 1ns/1ps
`include "hsmb_defs.svh"
module hsmb_bridge (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Host I/O register port
  input wire logic [9:0] regAddr,
  input wire logic [15:0] regWrData,
  input wire logic regWr,
  input wire logic regRd,
  output logic [15:0] regRdData,
  // Host memory cycle port
  input wire logic [23:0] hostMemAddr,
  input wire logic [1:0] hostMemBe,
  input wire logic [15:0] hostMemWrData,
  input wire logic hostMemRd,
  input wire logic hostMemWr,
  output logic hostMemSel,
  output logic hostMemWait,
  output logic hostMemDone,
  output logic [15:0] hostMemRdData,
  // Fitted buffer size strap
  input wire logic [2:0] memSizeSel,
  // Processor side
  output logic dspResetN,
  input wire logic dspReq,
  input wire logic dspWe,
  input wire logic [20:0] dspAddr,
  input wire logic [31:0] dspWrData,
  output logic dspGnt,
  output logic dspAck,
  output logic [31:0] dspRdData,
  // Shared buffer memory port
  output logic memEn,
  output logic memWe,
  output logic [20:0] memAddr,
  output logic [3:0] memBe,
  output logic [31:0] memWrData,
  input wire logic [31:0] memRdData
);

  // ----------------------------------------------------------
  // Control registers
  // ----------------------------------------------------------
  logic memEnable_r;
  logic dspRun_r;
  hsmb_pkg::hsmb_map_e mapMode_r;
  logic [3:0] extBase_r;
  logic [6:0] page_r;
  logic [7:0] pageBase_r;
  logic [7:0] conflictCnt_r;
  logic [15:0] regRdData_r;
  logic ioHit;
  logic [2:0] regIdx;
  logic [2:0] sizeCode;

  // I/O space decode is separate from the memory window
  assign ioHit = regAddr[9:3] == `HSMB_IO_BASE;
  assign regIdx = regAddr[2:0];
  assign sizeCode = (memSizeSel > `HSMB_SIZE_MAX) ?
                    `HSMB_SIZE_MAX : memSizeSel;

  // Power-up leaves the window closed and the processor in reset
  always_ff @(posedge clk) begin
    if (rst) begin
      memEnable_r <= 1'b0;
      dspRun_r <= 1'b0;
      mapMode_r <= hsmb_pkg::HSMB_MAP_EXT;
    end else if (regWr && ioHit && regIdx == `HSMB_REG_CTRL) begin
      memEnable_r <= regWrData[`HSMB_CTRL_MEMEN];
      dspRun_r <= regWrData[`HSMB_CTRL_RUN];
      mapMode_r <= hsmb_pkg::hsmb_map_e'(regWrData[`HSMB_CTRL_PAGED]);
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      extBase_r <= `HSMB_RST_EXTBASE;
    end else if (regWr && ioHit && regIdx == `HSMB_REG_EXTBASE) begin
      extBase_r <= regWrData[3:0];
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      page_r <= `HSMB_RST_PAGE;
    end else if (regWr && ioHit && regIdx == `HSMB_REG_PAGE) begin
      page_r <= regWrData[6:0];
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      pageBase_r <= `HSMB_RST_PAGEBASE;
    end else if (regWr && ioHit && regIdx == `HSMB_REG_PAGEBASE) begin
      pageBase_r <= regWrData[7:0];
    end
  end

  // Processor reset follows the run bit, at any time
  always_ff @(posedge clk) begin
    if (rst) begin
      dspResetN <= 1'b0;
    end else begin
      dspResetN <= dspRun_r;
    end
  end

  // ----------------------------------------------------------
  // Host window decode
  // ----------------------------------------------------------
  logic extHit;
  logic pagedHit;
  logic [20:0] hostWord;
  logic inRange;
  logic hostHit;
  logic hostCmd;

  // Full 24-bit host address, a 16 MB span
  assign extHit = extBase_r != 4'h0 &&
                  hostMemAddr[23:20] == extBase_r;
  assign pagedHit = hostMemAddr[23:16] == pageBase_r;

  // Upper page bits pick the 1 MB bank in extended mode
  always_comb begin
    if (mapMode_r == hsmb_pkg::HSMB_MAP_PAGED) begin
      hostWord = {page_r, hostMemAddr[15:2]};
    end else begin
      hostWord = {page_r[6:4], hostMemAddr[19:2]};
    end
  end

  // Addresses past the fitted buffer are not claimed
  always_comb begin
    case (sizeCode)
      3'h0: inRange = hostWord[20:17] == 4'h0;
      3'h1: inRange = hostWord[20:18] == 3'h0;
      3'h2: inRange = hostWord[20:19] == 2'h0;
      3'h3: inRange = !hostWord[20];
      default: inRange = 1'b1;
    endcase
  end

  assign hostCmd = hostMemRd || hostMemWr;
  assign hostHit = memEnable_r && inRange &&
                   (mapMode_r == hsmb_pkg::HSMB_MAP_PAGED ?
                    pagedHit : extHit);

  // ----------------------------------------------------------
  // Host cycle sequencer
  // ----------------------------------------------------------
  hsmb_pkg::hsmb_host_state_e hostState_r;
  logic [20:0] hostWord_r;
  logic hostHalf_r;
  logic hostWe_r;
  logic [1:0] hostBe_r;
  logic [15:0] hostWrData_r;
  logic [15:0] hostMemRdData_r;
  logic hostReq;
  logic gntHost;
  logic contended;

  // Commands during a busy cycle are dropped; wait holds the host
  always_ff @(posedge clk) begin
    if (rst) begin
      hostState_r <= hsmb_pkg::HS_IDLE;
    end else begin
      unique case (hostState_r)
        hsmb_pkg::HS_IDLE: begin
          if (hostCmd && hostHit) begin
            hostState_r <= hsmb_pkg::HS_REQ;
          end
        end
        hsmb_pkg::HS_REQ: begin
          if (gntHost) begin
            hostState_r <= hostWe_r ? hsmb_pkg::HS_DONE :
                           hsmb_pkg::HS_RDATA;
          end
        end
        hsmb_pkg::HS_RDATA: hostState_r <= hsmb_pkg::HS_DONE;
        hsmb_pkg::HS_DONE: hostState_r <= hsmb_pkg::HS_IDLE;
      endcase
    end
  end

  // Capture the cycle so the host bus may float behind wait
  always_ff @(posedge clk) begin
    if (rst) begin
      hostWord_r <= 21'h000000;
      hostHalf_r <= 1'b0;
      hostWe_r <= 1'b0;
      hostBe_r <= 2'h0;
      hostWrData_r <= 16'h0000;
    end else if (hostState_r == hsmb_pkg::HS_IDLE && hostCmd &&
                 hostHit) begin
      hostWord_r <= hostWord;
      hostHalf_r <= hostMemAddr[1];
      hostWe_r <= hostMemWr;
      hostBe_r <= hostMemBe;
      hostWrData_r <= hostMemWrData;
    end
  end

  // Pick the addressed half of the 32-bit word
  always_ff @(posedge clk) begin
    if (rst) begin
      hostMemRdData_r <= 16'h0000;
    end else if (hostState_r == hsmb_pkg::HS_RDATA) begin
      hostMemRdData_r <= hostHalf_r ? memRdData[31:16] :
                         memRdData[15:0];
    end
  end

  assign hostReq = hostState_r == hsmb_pkg::HS_REQ;
  assign hostMemSel = hostHit;
  assign hostMemWait = (hostState_r == hsmb_pkg::HS_IDLE) ?
                       (hostCmd && hostHit) :
                       (hostState_r != hsmb_pkg::HS_DONE);
  assign hostMemDone = hostState_r == hsmb_pkg::HS_DONE;
  assign hostMemRdData = hostMemRdData_r;

  // ----------------------------------------------------------
  // Arbitration and buffer port
  // ----------------------------------------------------------
  logic dspReqGated;

  // A processor held in reset can not take the buffer
  assign dspReqGated = dspReq && dspResetN;

  hsmb_arbiter u_arb (
    .clk(clk),
    .rst(rst),
    .hostReq(hostReq),
    .dspReq(dspReqGated),
    .gntHost(gntHost),
    .gntDsp(dspGnt),
    .contended(contended)
  );

  // Only one side drives the buffer in any cycle
  always_comb begin
    memEn = gntHost || dspGnt;
    if (gntHost) begin
      memWe = hostWe_r;
      memAddr = hostWord_r;
      memWrData = {hostWrData_r, hostWrData_r};
      memBe = hostHalf_r ? {hostBe_r, 2'h0} : {2'h0, hostBe_r};
    end else begin
      memWe = dspGnt && dspWe;
      memAddr = dspAddr;
      memWrData = dspWrData;
      memBe = 4'hF;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      dspAck <= 1'b0;
    end else begin
      dspAck <= dspGnt;
    end
  end

  // RAM output register feeds the processor directly
  assign dspRdData = memRdData;

  // ----------------------------------------------------------
  // Collision counter and register readback
  // ----------------------------------------------------------
  logic statClr;

  assign statClr = regWr && ioHit && regIdx == `HSMB_REG_STATUS;

  // A collision in the clearing cycle is still counted
  always_ff @(posedge clk) begin
    if (rst) begin
      conflictCnt_r <= 8'h00;
    end else if (contended) begin
      if (statClr) begin
        conflictCnt_r <= 8'h01;
      end else if (conflictCnt_r != 8'hFF) begin
        conflictCnt_r <= conflictCnt_r + 8'h01;
      end
    end else if (statClr) begin
      conflictCnt_r <= 8'h00;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      regRdData_r <= 16'h0000;
    end else if (regRd && ioHit) begin
      unique case (regIdx)
        `HSMB_REG_CTRL: regRdData_r <= {13'h0000, mapMode_r == 
          hsmb_pkg::HSMB_MAP_PAGED, dspRun_r, memEnable_r};
        `HSMB_REG_EXTBASE: regRdData_r <= {12'h000, extBase_r};
        `HSMB_REG_PAGE: regRdData_r <= {9'h000, page_r};
        `HSMB_REG_PAGEBASE: regRdData_r <= {8'h00, pageBase_r};
        `HSMB_REG_STATUS: regRdData_r <= {conflictCnt_r, 3'h0,
          sizeCode, dspResetN, hostState_r != hsmb_pkg::HS_IDLE};
        default: regRdData_r <= 16'h0000;
      endcase
    end else begin
      regRdData_r <= 16'h0000;
    end
  end

  assign regRdData = regRdData_r;

  // ----------------------------------------------------------
  // Checks
  // ----------------------------------------------------------
  a_window_closed: assert property (
    @(posedge clk) disable iff (rst)
    $rose(hostMemWait) |-> memEnable_r)
    else $error("host cycle claimed while mapping disabled");

  a_io_miss_zero: assert property (
    @(posedge clk) disable iff (rst)
    regRd && !ioHit |=> regRdData == 16'h0000)
    else $error("unmapped I/O read returned data");

  a_reset_no_grant: assert property (
    @(posedge clk) disable iff (rst)
    !dspRun_r |=> !dspGnt)
    else $error("processor granted while held in reset");

  a_half_lanes: assert property (
    @(posedge clk) disable iff (rst)
    gntHost |-> (memBe[3:2] == 2'h0 || memBe[1:0] == 2'h0))
    else $error("host access drove both halves");

  a_fitted_size: assert property (
    @(posedge clk) disable iff (rst)
    gntHost && sizeCode == 3'h0 |-> memAddr[20:17] == 4'h0)
    else $error("host access beyond fitted buffer");

  a_ext_bounds: assert property (
    @(posedge clk) disable iff (rst)
    hostMemSel && mapMode_r == hsmb_pkg::HSMB_MAP_EXT |->
    hostMemAddr[23:20] != 4'h0 && hostMemAddr[23:20] == extBase_r)
    else $error("extended window outside 1-16 MB");

  a_page_segment: assert property (
    @(posedge clk) disable iff (rst)
    hostMemSel && hostCmd && hostState_r == hsmb_pkg::HS_IDLE &&
    mapMode_r == hsmb_pkg::HSMB_MAP_PAGED ##1 gntHost |->
    memAddr[20:14] == $past(page_r))
    else $error("paged window ignored the page register");

  a_wait_bound: assert property (
    @(posedge clk) disable iff (rst)
    hostState_r == hsmb_pkg::HS_IDLE && hostCmd && hostHit |->
    hostMemWait ##1 hostMemWait[*1] ##[1:3] hostMemDone)
    else $error("host cycle not finished in bounded time");

endmodule

// ### verilog/hsmb_defs.svh
// Constants for the host shared memory window bridge.
// Assumes a 16-bit ISA-style host side and a 32-bit shared buffer RAM.
//
// Functional notes
// - No host memory response until mapping enabled
// - Decode separate I/O and memory host spaces
// - Processor held in reset until run bit
// - Arbitrate and serialize simultaneous buffer accesses
// - Convert 32-bit buffer words to 16-bit host
// - Buffer 32 bits wide, 128k to 2M words
// - Extended mode: 1 MB window between 1-16 MB
// - Paged mode: 64 kB window below 16 MB
// - Page register selects visible 64 kB segment
// - Host decoding spans 16 MB of addresses
`ifndef HSMB_DEFS_SVH
`define HSMB_DEFS_SVH

// I/O block sits at host I/O 0x300, eight word slots holding five registers
`define HSMB_IO_BASE 7'h60
`define HSMB_REG_CTRL 3'h0
`define HSMB_REG_EXTBASE 3'h1
`define HSMB_REG_PAGE 3'h2
`define HSMB_REG_PAGEBASE 3'h3
`define HSMB_REG_STATUS 3'h4

// Control register fields
`define HSMB_CTRL_MEMEN 0
`define HSMB_CTRL_RUN 1
`define HSMB_CTRL_PAGED 2

// Status register fields
`define HSMB_STAT_BUSY 0
`define HSMB_STAT_RUN 1
`define HSMB_STAT_SIZE_LO 2
`define HSMB_STAT_CNT_LO 8

// Reset values
`define HSMB_RST_EXTBASE 4'h1
`define HSMB_RST_PAGE 7'h00
`define HSMB_RST_PAGEBASE 8'h0D

// Largest legal fitted-size code: 2M words
`define HSMB_SIZE_MAX 3'h4

`endif

// ### verilog/hsmb_pkg.sv
// Types shared by the bridge modules.
// Assumes the constants header is compiled alongside.
package hsmb_pkg;

  typedef enum {
    HS_IDLE,
    HS_REQ,
    HS_RDATA,
    HS_DONE
  } hsmb_host_state_e;

  typedef enum logic {
    HSMB_MAP_EXT,
    HSMB_MAP_PAGED
  } hsmb_map_e;

endpackage

// ### verilog/hsmb_arbiter.sv
// Two-way arbiter for the shared buffer memory port.
// Assumes each requester holds its request until granted.
`timescale 1ns/1ps
module hsmb_arbiter (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Requests
  input wire logic hostReq,
  input wire logic dspReq,
  // Grants
  output logic gntHost,
  output logic gntDsp,
  output logic contended
);

  logic lastHost_r;

  // Alternate on collision so neither side starves
  always_comb begin
    contended = hostReq && dspReq;
    if (contended) begin
      gntHost = !lastHost_r;
      gntDsp = lastHost_r;
    end else begin
      gntHost = hostReq;
      gntDsp = dspReq;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      lastHost_r <= 1'b0;
    end else if (gntHost || gntDsp) begin
      lastHost_r <= gntHost;
    end
  end

  a_grant_exclusive: assert property (
    @(posedge clk) disable iff (rst) !(gntHost && gntDsp))
    else $error("both sides granted the buffer");

  // Host, when it loses a collision, is served in the very next cycle
  a_grant_alternates: assert property (
    @(posedge clk) disable iff (rst)
    contended && gntDsp && hostReq |=> gntHost)
    else $error("host not served after losing a collision");

endmodule

// ### dv/hsmb_far_model.sv
// Far-side model: the synchronous shared buffer memory, 32-bit words.
// Assumes byte enables and read data one cycle after the enable.
`timescale 1ns/1ps
module hsmb_far_model (
  // Clock
  input wire logic clk,
  // Buffer port
  input wire logic memEn,
  input wire logic memWe,
  input wire logic [20:0] memAddr,
  input wire logic [3:0] memBe,
  input wire logic [31:0] memWrData,
  output logic [31:0] memRdData
);
  // Only the smallest fitted size is kept, so higher words alias
  logic [31:0] store [0:131071];
  logic [31:0] word_r;
  logic valid_r;

  always @(posedge clk) begin
    valid_r <= memEn && !memWe;
    if (memEn && memWe) begin
      for (int i = 0; i < 4; i++) begin
        if (memBe[i]) begin
          store[memAddr[16:0]][8*i +: 8] <= memWrData[8*i +: 8];
        end
      end
    end
    if (memEn && !memWe) begin
      word_r <= store[memAddr[16:0]];
    end
  end

  // Data is not held past its cycle, so a late sample sees garbage
  assign memRdData = valid_r ? word_r : ~word_r;
endmodule

// ### dv/tb_hsmb_bridge.sv
// Self-checking testbench for the host shared memory window bridge.
// Assumes the far-side buffer model and a 100 ns clock.
`timescale 1ns/1ps
module tb_hsmb_bridge;
  logic clk, rst, regWr, regRd, hostMemRd, hostMemWr, g;
  logic [9:0] regAddr;
  logic [15:0] regWrData, regRdData, hostMemWrData, hostMemRdData, q;
  logic [23:0] hostMemAddr;
  logic [1:0] hostMemBe;
  logic [2:0] memSizeSel;
  logic hostMemSel, hostMemWait, hostMemDone, dspResetN;
  logic dspReq, dspWe, dspGnt, dspAck, memEn, memWe;
  logic [20:0] dspAddr, memAddr, capAddr;
  logic [31:0] dspWrData, dspRdData, memWrData, memRdData, q32;
  logic [3:0] memBe, capBe;
  int failures, cmp_count;

  hsmb_bridge dut (.clk(clk), .rst(rst), .regAddr(regAddr),
    .regWrData(regWrData), .regWr(regWr), .regRd(regRd),
    .regRdData(regRdData), .hostMemAddr(hostMemAddr),
    .hostMemBe(hostMemBe), .hostMemWrData(hostMemWrData),
    .hostMemRd(hostMemRd), .hostMemWr(hostMemWr), .hostMemSel(hostMemSel),
    .hostMemWait(hostMemWait), .hostMemDone(hostMemDone),
    .hostMemRdData(hostMemRdData), .memSizeSel(memSizeSel),
    .dspResetN(dspResetN), .dspReq(dspReq), .dspWe(dspWe),
    .dspAddr(dspAddr), .dspWrData(dspWrData), .dspGnt(dspGnt),
    .dspAck(dspAck), .dspRdData(dspRdData), .memEn(memEn), .memWe(memWe),
    .memAddr(memAddr), .memBe(memBe), .memWrData(memWrData),
    .memRdData(memRdData));
  hsmb_far_model far (.clk(clk), .memEn(memEn), .memWe(memWe),
    .memAddr(memAddr), .memBe(memBe), .memWrData(memWrData),
    .memRdData(memRdData));

  // Host-side buffer accesses only; processor grants are skipped
  always @(posedge clk) begin
    if (memEn && !dspGnt) begin
      capAddr <= memAddr;
      capBe <= memBe;
    end
  end

  // ----------------------------------------
  // Shared tasks
  // ----------------------------------------
  task chk(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      failures++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task wr(input logic [9:0] a, input logic [15:0] d);
    @(posedge clk);
    regAddr <= a;
    regWrData <= d;
    regWr <= 1'b1;
    @(posedge clk);
    regWr <= 1'b0;
  endtask

  task rd(input logic [9:0] a, input logic [15:0] exp);
    @(posedge clk);
    regAddr <= a;
    regRd <= 1'b1;
    @(posedge clk);
    regRd <= 1'b0;
    #1 chk(regRdData, exp);
  endtask

  // Address is held until done; a miss must stay silent for 8 cycles
  task hm(input logic [23:0] a, input logic w, input logic [15:0] d,
          input logic [1:0] be, input logic hit);
    int n;
    @(posedge clk);
    hostMemAddr <= a;
    hostMemWr <= w;
    hostMemRd <= !w;
    hostMemWrData <= d;
    hostMemBe <= be;
    #1 chk(hostMemWait, hit);
    chk(hostMemSel, hit);
    @(posedge clk);
    hostMemRd <= 1'b0;
    hostMemWr <= 1'b0;
    n = 1;
    #1 while (hostMemDone !== 1'b1 && n < 8) begin
      @(posedge clk);
      #1 n++;
    end
    chk(hostMemDone, hit);
    q = hostMemRdData;
  endtask

  task dsp(input logic [20:0] a, input logic w, input logic [31:0] d);
    int n;
    @(posedge clk);
    dspReq <= 1'b1;
    dspWe <= w;
    dspAddr <= a;
    dspWrData <= d;
    n = 0;
    #1 while (dspGnt !== 1'b1 && n < 6) begin
      @(posedge clk);
      #1 n++;
    end
    g = dspGnt;
    @(posedge clk);
    dspReq <= 1'b0;
    #1 chk(dspAck, g);
    q32 = dspRdData;
  endtask

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task t_reset;
    rd(10'h300, 16'h0000);
    chk(dspResetN, 1'b0);
    rd(10'h301, 16'h0001);
    rd(10'h303, 16'h000D);
    rd(10'h304, 16'h0010);
    rd(10'h305, 16'h0000);
    rd(10'h200, 16'h0000);
    hm(24'h100010, 1'b0, 16'h0000, 2'h3, 1'b0);
    $display("test reset done");
  endtask

  task t_run;
    dsp(21'h4, 1'b1, 32'h0);
    chk(g, 1'b0);
    wr(10'h300, 16'h0003);
    rd(10'h304, 16'h0012);
    chk(dspResetN, 1'b1);
    $display("test run done");
  endtask

  task t_ext;
    dsp(21'h4, 1'b1, 32'h12345678);
    hm(24'h100010, 1'b0, 16'h0000, 2'h3, 1'b1);
    chk(q, 16'h5678);
    hm(24'h100012, 1'b0, 16'h0000, 2'h3, 1'b1);
    chk(q, 16'h1234);
    hm(24'h100012, 1'b1, 16'hBEEF, 2'h3, 1'b1);
    chk(capAddr, 21'h4);
    chk(capBe, 4'hC);
    hm(24'h100011, 1'b1, 16'h00AA, 2'h1, 1'b1);
    chk(capBe, 4'h1);
    dsp(21'h4, 1'b0, 32'h0);
    chk(q32, 32'hBEEF56AA);
    hm(24'h200010, 1'b0, 16'h0000, 2'h3, 1'b0);
    wr(10'h301, 16'h0000);
    hm(24'h100010, 1'b0, 16'h0000, 2'h3, 1'b0);
    wr(10'h301, 16'h0002);
    wr(10'h302, 16'h0010);
    hm(24'h200010, 1'b0, 16'h0000, 2'h3, 1'b1);
    chk(capAddr, 21'h040004);
    $display("test extended done");
  endtask

  task t_paged;
    wr(10'h300, 16'h0007);
    wr(10'h302, 16'h0003);
    dsp(21'h00C002, 1'b1, 32'hCAFEF00D);
    hm(24'h0D0008, 1'b0, 16'h0000, 2'h3, 1'b1);
    chk(q, 16'hF00D);
    chk(capAddr, 21'h00C002);
    hm(24'h200010, 1'b0, 16'h0000, 2'h3, 1'b0);
    wr(10'h302, 16'h0004);
    hm(24'h0D0008, 1'b0, 16'h0000, 2'h3, 1'b1);
    chk(capAddr, 21'h010002);
    wr(10'h303, 16'h00E0);
    hm(24'hE0FFFC, 1'b0, 16'h0000, 2'h3, 1'b1);
    chk(capAddr, 21'h013FFF);
    $display("test paged done");
  endtask

  // Processor asks in the host's buffer cycle, so both contend
  task t_collide;
    wr(10'h302, 16'h0003);
    wr(10'h303, 16'h000D);
    fork
      hm(24'h0D0008, 1'b0, 16'h0000, 2'h3, 1'b1);
      begin
        @(posedge clk);
        dsp(21'h4, 1'b0, 32'h0);
      end
    join
    chk(q, 16'hF00D);
    chk(q32, 32'hBEEF56AA);
    rd(10'h304, 16'h0112);
    wr(10'h304, 16'h0000);
    rd(10'h304, 16'h0012);
    $display("test collide done");
  endtask

  task t_restart;
    wr(10'h300, 16'h0005);
    rd(10'h304, 16'h0010);
    chk(dspResetN, 1'b0);
    wr(10'h300, 16'h0007);
    rd(10'h304, 16'h0012);
    $display("test restart done");
  endtask

  // Smaller straps shrink the claimed part of the window
  task t_size;
    @(posedge clk);
    memSizeSel <= 3'h0;
    rd(10'h304, 16'h0002);
    hm(24'h0D0008, 1'b0, 16'h0000, 2'h3, 1'b1);
    chk(q, 16'hF00D);
    wr(10'h302, 16'h0008);
    hm(24'h0D0008, 1'b0, 16'h0000, 2'h3, 1'b0);
    @(posedge clk);
    memSizeSel <= 3'h7;
    rd(10'h304, 16'h0012);
    hm(24'h0D0008, 1'b1, 16'h1234, 2'h3, 1'b1);
    chk(capAddr, 21'h020002);
    $display("test size done");
  endtask

  task end_of_test;
    $display("comparisons %0d mismatches %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  // ----------------------------------------
  // Clock, sequence and watchdog
  // ----------------------------------------
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  initial begin
    rst = 1'b1;
    {regWr, regRd, hostMemRd, hostMemWr, dspReq, dspWe} = 6'h00;
    regAddr = 10'h000;
    regWrData = 16'h0000;
    hostMemAddr = 24'h000000;
    hostMemBe = 2'h0;
    hostMemWrData = 16'h0000;
    memSizeSel = 3'h4;
    dspAddr = 21'h000000;
    dspWrData = 32'h00000000;
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    t_reset;
    t_run;
    t_ext;
    t_paged;
    t_collide;
    t_restart;
    t_size;
    end_of_test;
  end

  // Run needs a few hundred cycles; give up after 20000
  initial begin
    #2000000;
    failures++;
    end_of_test;
  end
endmodule
